// ---- hdl/srbt_pkg.sv ----
// Purpose: Shared constants for the read burst and turnaround block
// Assumes: Link counts are in memory clock cycles, not core cycles
// Notes:   Mode codes follow the burst length field of mode register zero
package srbt_pkg;
  localparam int        CNT_W           = 8;      // Width of the link clock counters
  localparam logic [7:0] CNT_MAX        = 8'hFF;  // Saturation value of the gap counters
  localparam logic [7:0] CNT_ONE        = 8'h01;  // One link clock
  localparam logic [3:0] BEATS_FULL     = 4'h8;   // Full eight-beat burst
  localparam logic [3:0] BEATS_CHOP     = 4'h4;   // Chopped four-beat burst
  localparam logic [1:0] MODE_FIXED_FULL = 2'h0;  // Burst field: fixed full burst
  localparam logic [1:0] MODE_PER_CMD   = 2'h1;   // Burst field: per-command select
  localparam logic [1:0] MODE_FIXED_CHOP = 2'h2;  // Burst field: fixed chopped burst
  localparam logic [7:0] DRIVE_FULL_CK  = 8'h04;  // Drive window after read latency, full burst
  localparam logic [7:0] DRIVE_CHOP_CK  = 8'h02;  // Drive window after read latency, chopped burst
  localparam logic [8:0] TURN_EXTRA_CK  = 9'h001; // Extra clock in the read-to-write gap
  localparam logic [2:0] BEAT_RESET     = 3'h0;   // Beat index after reset
endpackage : srbt_pkg

// ---- hdl/srbt_link_sync.sv ----
// Purpose: Bring the memory clock and command pins into the core clock domain
// Assumes: Core clock is several times faster than the memory clock
// Notes:   Edges are found on the second stage only; first stage feeds nothing else
module srbt_link_sync #(
  parameter int W = 5                          // Number of command pins
) (
  input  wire logic         core_clk,          // Core clock
  input  wire logic         rstn,              // Asynchronous reset, active low
  input  wire logic         linkClk,           // Memory clock pin
  input  wire logic [W-1:0] pins,              // Command pins, raw
  output logic              linkRise,          // One-cycle pulse on a memory clock rise
  output logic              linkFall,          // One-cycle pulse on a memory clock fall
  output logic [W-1:0]      pinsSync           // Command pins after two flops
);
  typedef struct packed {
    logic [W:0] s1;                            // First synchroniser stage
    logic [W:0] s2;                            // Second synchroniser stage
    logic       prevClk;                       // Last synchronised clock level
  } srbt_sync_t;

  srbt_sync_t st;                              // Registered state
  srbt_sync_t next_st;                         // Next state

  // Shift both stages; clock and pins share one delay so they stay aligned
  always_comb begin
    next_st         = st;
    next_st.s1      = {pins, linkClk};
    next_st.s2      = st.s1;
    next_st.prevClk = st.s2[0];
  end

  // State register
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign linkRise = st.s2[0] & ~st.prevClk;   // Rise seen on the settled stage
  assign linkFall = ~st.s2[0] & st.prevClk;   // Fall seen on the settled stage
  assign pinsSync = st.s2[W:1];
endmodule : srbt_link_sync

// ---- hdl/srbt_read_burst.sv ----
// Purpose: Read data framing and command turnaround watch of a DRAM read path
// Assumes: Additive latency zero, so read latency equals the read CAS latency
// Notes:   One read is tracked at a time; a read during a burst drives no data but still updates readBurstBeats and the gap checks
// What this block does
// - Read burst term eight full, four chopped
// - Write burst term four only fixed chop
// - Full burst drives from latency to +4
// - Chopped burst stops driving at latency +2
// - Full burst by fixed code or select high
// - Read timing only with locked loop
// - Select bit low chooses chopped burst; writes on the fly stay at eight
module srbt_read_burst #(
  parameter int DQ_W = 8                          // Data pins per beat
) (
  input  wire logic                core_clk,      // Core clock, 40 MHz
  input  wire logic                rstn,          // Asynchronous reset, active low
  input  wire logic                linkClk,       // Memory clock pin
  input  wire logic                cmdRead,       // Read command pin, high for a read
  input  wire logic                cmdWrite,      // Write command pin, high for a write
  input  wire logic                burstSelect,   // Per-command burst select address bit
  input  wire logic [1:0]          bankGroup,     // Bank group of the command
  input  wire logic [1:0]          burstMode,     // Burst field of mode register zero
  input  wire logic [5:0]          readCasLatency,  // Read latency in memory clocks
  input  wire logic [5:0]          writeCasLatency, // Write latency in memory clocks
  input  wire logic [1:0]          writePreambleTime, // Write preamble in memory clocks
  input  wire logic [3:0]          wrToRdDelayLong,   // Write-to-read delay, same group
  input  wire logic [3:0]          wrToRdDelayShort,  // Write-to-read delay, other group
  input  wire logic                dllLocked,     // Delay-locked loop enabled and locked
  input  wire logic [8*DQ_W-1:0]   burstData,     // Eight beats of read data, beat 0 low
  output logic [DQ_W-1:0]          dqOut,         // Data pins, driven value
  output logic                     dqOe,          // Data pins output enable
  output logic [3:0]               readBurstBeats,  // Beat count of the last read
  output logic [3:0]               writeBurstBeats, // Beat term of the last write
  output logic                     rdToWrViolation, // Pulse: write came too soon after read
  output logic                     wrToRdViolation  // Pulse: read came too soon after write
);
  typedef struct packed {
    logic                busy;        // A read is waiting or bursting
    logic                chop;        // Current read is a chopped burst
    logic [7:0]          clkCnt;      // Memory clocks since the read command
    logic [2:0]          beat;        // Next beat to drive
    logic                oe;          // Drive enable
    logic [DQ_W-1:0]     dq;          // Driven beat
    logic [8*DQ_W-1:0]   data;        // Captured burst
    logic [7:0]          sinceRead;   // Memory clocks since last read
    logic [7:0]          sinceWrite;  // Memory clocks since last write
    logic [3:0]          rdBeats;     // Read burst term of the last read
    logic [3:0]          wrBeats;     // Write burst term of the last write
    logic [1:0]          wrGroup;     // Bank group of the last write
    logic                rdWrErr;     // Read-to-write spacing pulse
    logic                wrRdErr;     // Write-to-read spacing pulse
  } srbt_state_t;

  srbt_state_t st;                    // Registered state
  srbt_state_t next_st;               // Next state
  logic        linkRise;              // Memory clock rise pulse
  logic        linkFall;              // Memory clock fall pulse
  logic [4:0]  pinsSync;              // Synchronised command pins

  // Burst term of a command from the mode field and the select bit
  function automatic logic [3:0] burstBeats(input logic [1:0] mode, input logic sel, input logic isWrite);
    logic [3:0] b;
    b = srbt_pkg::BEATS_FULL;
    if (mode == srbt_pkg::MODE_FIXED_CHOP) begin
      b = srbt_pkg::BEATS_CHOP;
    end else if (mode == srbt_pkg::MODE_PER_CMD && !sel && !isWrite) begin
      b = srbt_pkg::BEATS_CHOP;
    end
    return b;                                                 // Writes on the fly stay at eight
  endfunction : burstBeats

  // Saturating increment of a gap counter
  function automatic logic [7:0] satInc(input logic [7:0] v);
    return (v == srbt_pkg::CNT_MAX) ? v : v + srbt_pkg::CNT_ONE;
  endfunction : satInc

  srbt_link_sync #(.W(5)) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .linkClk  (linkClk),
    .pins     ({bankGroup, burstSelect, cmdWrite, cmdRead}),
    .linkRise (linkRise),
    .linkFall (linkFall),
    .pinsSync (pinsSync)
  );

  logic       rdS;          // Synchronised read
  logic       wrS;          // Synchronised write
  logic       selS;         // Synchronised burst select
  logic [1:0] bgS;          // Synchronised bank group
  logic       readTake;     // Read accepted at this rise
  logic [7:0] cnt1;         // Clock count at this rise
  logic [7:0] readLat;      // Read latency widened
  logic [3:0] rdNew;        // Burst term of an arriving read
  logic [3:0] wrNew;        // Burst term of an arriving write
  logic [8:0] rdWrHave;     // Gap seen, offset by write latency
  logic [8:0] rdWrNeed;     // Least read-to-write gap, offset by write latency
  logic [8:0] wrRdNeed;     // Least write-to-read gap

  assign rdS   = pinsSync[0];
  assign wrS   = pinsSync[1];
  assign selS  = pinsSync[2];
  assign bgS   = pinsSync[4:3];
  assign cnt1  = st.clkCnt + srbt_pkg::CNT_ONE;
  assign readLat = {2'h0, readCasLatency};
  assign rdNew = burstBeats(burstMode, selS, 1'b0);
  assign wrNew = burstBeats(burstMode, selS, 1'b1);
  // Latency difference kept as a sum on both sides so it never goes negative
  assign rdWrHave = {1'b0, st.sinceRead} + {3'h0, writeCasLatency};
  assign rdWrNeed = {3'h0, readCasLatency} + {6'h0, st.rdBeats[3:1]} + srbt_pkg::TURN_EXTRA_CK
                  + {7'h0, writePreambleTime};
  assign wrRdNeed = {3'h0, writeCasLatency} + {6'h0, st.wrBeats[3:1]}
                  + {5'h0, (bgS == st.wrGroup) ? wrToRdDelayLong : wrToRdDelayShort};
  // No read output without a locked loop; the strobe timing would be undefined
  assign readTake = linkRise && rdS && !st.busy && dllLocked;

  // Command tracking, spacing checks and burst framing
  always_comb begin
    next_st         = st;
    next_st.rdWrErr = 1'b0;
    next_st.wrRdErr = 1'b0;
    if (linkRise) begin
      // Gap counters advance each memory clock
      next_st.sinceRead  = satInc(st.sinceRead);
      next_st.sinceWrite = satInc(st.sinceWrite);
      next_st.clkCnt     = cnt1;
      if (wrS) begin
        next_st.rdWrErr    = (rdWrHave < rdWrNeed);
        next_st.sinceWrite = srbt_pkg::CNT_ONE;
        next_st.wrBeats    = wrNew;
        next_st.wrGroup    = bgS;
      end
      if (rdS) begin
        next_st.wrRdErr   = ({1'b0, st.sinceWrite} < wrRdNeed);
        next_st.sinceRead = srbt_pkg::CNT_ONE;
        next_st.rdBeats   = rdNew;
      end
      if (readTake) begin
        next_st.busy   = 1'b1;
        next_st.chop   = (rdNew == srbt_pkg::BEATS_CHOP);
        next_st.clkCnt = '0;
        next_st.data   = burstData;
        next_st.beat   = srbt_pkg::BEAT_RESET;
      end else if (st.busy && !st.oe && cnt1 == readLat) begin
        // First beat goes out on the rise at read latency
        next_st.oe   = 1'b1;
        next_st.dq   = st.data[DQ_W-1:0];
        next_st.beat = 3'h1;
      end else if (st.oe && cnt1 == readLat + (st.chop ? srbt_pkg::DRIVE_CHOP_CK
                                                       : srbt_pkg::DRIVE_FULL_CK)) begin
        next_st.oe   = 1'b0;
        next_st.busy = 1'b0;
      end else if (st.oe) begin
        next_st.dq   = st.data[st.beat*DQ_W +: DQ_W];
        next_st.beat = st.beat + 3'h1;
      end
    end else if (linkFall && st.oe) begin
      // Second beat of each clock on the falling edge
      next_st.dq   = st.data[st.beat*DQ_W +: DQ_W];
      next_st.beat = st.beat + 3'h1;
    end
  end

  // State register; gap counters start saturated so the first command is clean
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st            <= '0;
      st.sinceRead  <= srbt_pkg::CNT_MAX;
      st.sinceWrite <= srbt_pkg::CNT_MAX;
      st.rdBeats    <= srbt_pkg::BEATS_FULL;
      st.wrBeats    <= srbt_pkg::BEATS_FULL;
    end else begin
      st <= next_st;
    end
  end

  assign dqOut           = st.dq;
  assign dqOe            = st.oe;
  assign readBurstBeats  = st.rdBeats;
  assign writeBurstBeats = st.wrBeats;
  assign rdToWrViolation = st.rdWrErr;
  assign wrToRdViolation = st.wrRdErr;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_read_full_term: assert property (linkRise && rdS && (burstMode == srbt_pkg::MODE_FIXED_FULL)
    |=> st.rdBeats == 4'h8) else $error("full read term not eight");
  chk_read_chop_term: assert property (linkRise && rdS && (burstMode == srbt_pkg::MODE_PER_CMD) && !selS
    |=> st.rdBeats == 4'h4) else $error("select low did not chop");
  chk_write_cmd_term: assert property (linkRise && wrS && (burstMode == srbt_pkg::MODE_PER_CMD)
    |=> st.wrBeats == 4'h8) else $error("on the fly write term not eight");
  chk_full_select: assert property (readTake && (burstMode == srbt_pkg::MODE_PER_CMD) && selS
    |=> !st.chop && st.busy) else $error("select high did not give full burst");
  chk_drive_start: assert property ($rose(st.oe) |-> $past(linkRise) && $past(cnt1) == readLat)
    else $error("drive did not start at read latency");
  chk_full_stop: assert property ($fell(st.oe) && !st.chop |-> $past(cnt1) == readLat + 8'h04)
    else $error("full burst stop not at latency plus four");
  chk_chop_stop: assert property ($fell(st.oe) && st.chop |-> $past(cnt1) == readLat + 8'h02)
    else $error("chopped burst stop not at latency plus two");
  chk_dll_gate: assert property (linkRise && rdS && !st.busy && !dllLocked |=> !st.busy)
    else $error("read taken without locked loop");
  chk_beat_rate: assert property (st.oe && linkFall |=> st.beat == $past(st.beat) + 3'h1)
    else $error("beat did not advance on fall");
  chk_rdwr_gap: assert property (linkRise && wrS && (rdWrHave < rdWrNeed) |=> rdToWrViolation)
    else $error("short read-to-write gap not flagged");
  // A read that comes before the write-to-read gap has passed must raise the write-to-read flag
  chk_wrrd_gap: assert property (linkRise && rdS && ({1'b0, st.sinceWrite} < wrRdNeed)
    |=> wrToRdViolation) else $error("short write-to-read gap not flagged");
  chk_first_beat: assert property ($rose(st.oe) |-> dqOut == st.data[DQ_W-1:0])
    else $error("first beat not beat zero");

  cov_full_burst: cover property ($fell(st.oe) && !st.chop);
  cov_chop_burst: cover property ($fell(st.oe) && st.chop);
  cov_wr_rd_err:  cover property (wrToRdViolation);
  cov_rd_wr_err:  cover property (rdToWrViolation);
  cov_dll_refuse: cover property (linkRise && rdS && !dllLocked);
endmodule : srbt_read_burst

// ---- verification/srbt_ctrl_model.sv ----
// Purpose: Memory controller model that runs the memory clock and issues commands
// Assumes: Callers enter issue and idle at a memory clock fall
// Notes:   Clock runs free; idle select and group pins show the inverse of the last command
module srbt_ctrl_model (
  output logic       linkClk,     // Memory clock, 200 ns period
  output logic       cmdRead,     // Read command
  output logic       cmdWrite,    // Write command
  output logic       burstSelect, // Per-command burst select bit
  output logic [1:0] bankGroup    // Bank group of the command
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle pins at time zero
  initial begin
    linkClk = 1'b0;
    cmdRead = 1'b0;
    cmdWrite = 1'b0;
    burstSelect = 1'b0;
    bankGroup = 2'h0;
  end

  // Free-running memory clock, phase unrelated to the core clock
  always #100 linkClk = ~linkClk;

  // One command across exactly one rise; gap choice is the caller's
  task issue(input logic rd, input logic wr, input logic sel, input logic [1:0] bg);
    cmdRead = rd;
    cmdWrite = wr;
    burstSelect = sel; // Select bit picks the burst in per-command mode
    bankGroup = bg;
    @(negedge linkClk);
    cmdRead = 1'b0;
    cmdWrite = 1'b0;
    burstSelect = ~sel; // Inverse so a stale value is never mistaken for a hold
    bankGroup = ~bg;
  endtask : issue

  // Deselect for n memory clocks
  task idle(input int n);
    repeat (n) @(negedge linkClk);
  endtask : idle
endmodule : srbt_ctrl_model

// ---- verification/srbt_read_burst_tb.sv ----
// Purpose: Self-checking bench for read framing and command spacing flags
// Assumes: Write latency 4, preamble 1, long 4, short 2 memory clocks
// Notes:   Sample points sit mid-beat; sync delay never reaches them
module srbt_read_burst_tb;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED at %0t: got %0h expected %0h", $time, a, e); end end

  logic        core_clk;            // Core clock, 25 ns
  logic        rstn;                // Reset, active low
  logic [1:0]  burstMode;           // Mode register burst field
  logic [5:0]  readCasLatency;      // Read latency
  logic [5:0]  writeCasLatency;     // Write latency
  logic [1:0]  writePreambleTime;   // Write preamble
  logic [3:0]  wrToRdDelayLong;     // Same-group turnaround
  logic [3:0]  wrToRdDelayShort;    // Other-group turnaround
  logic        dllLocked;           // Loop locked
  logic [63:0] burstData;           // Read data beats
  wire         linkClk, cmdRead, cmdWrite, burstSelect; // Controller pins
  wire  [1:0]  bankGroup;           // Controller bank group
  logic [7:0]  dqOut;               // Driven beat
  logic        dqOe, rdToWrViolation, wrToRdViolation; // Enable and flags
  logic [3:0]  readBurstBeats, writeBurstBeats; // Burst terms
  logic        sawRw, sawWr, sawOe; // Sticky captures of pulses
  int          n_errors, n_compared; // Counters

  srbt_ctrl_model ctl (.linkClk(linkClk), .cmdRead(cmdRead), .cmdWrite(cmdWrite),
    .burstSelect(burstSelect), .bankGroup(bankGroup));
  srbt_read_burst #(.DQ_W(8)) dut (.core_clk(core_clk), .rstn(rstn), .linkClk(linkClk), .cmdRead(cmdRead),
    .cmdWrite(cmdWrite), .burstSelect(burstSelect), .bankGroup(bankGroup), .burstMode(burstMode),
    .readCasLatency(readCasLatency), .writeCasLatency(writeCasLatency), .writePreambleTime(writePreambleTime),
    .wrToRdDelayLong(wrToRdDelayLong), .wrToRdDelayShort(wrToRdDelayShort), .dllLocked(dllLocked),
    .burstData(burstData), .dqOut(dqOut), .dqOe(dqOe), .readBurstBeats(readBurstBeats),
    .writeBurstBeats(writeBurstBeats), .rdToWrViolation(rdToWrViolation), .wrToRdViolation(wrToRdViolation));

  // Core clock
  always #12.5 core_clk = ~core_clk;

  // One-cycle pulses would be missed by mid-beat sampling, so latch them
  always @(posedge core_clk) begin
    if (rdToWrViolation === 1'b1) sawRw <= 1'b1;
    if (wrToRdViolation === 1'b1) sawWr <= 1'b1;
    if (dqOe === 1'b1) sawOe <= 1'b1;
  end

  // Core-domain settings, then realign to a memory clock fall
  task setup(input logic [1:0] m, input logic [5:0] lat, input logic lk, input logic [63:0] d);
    @(posedge core_clk);
    #2 burstMode = m;
    readCasLatency = lat;
    dllLocked = lk;
    burstData = d;
    ctl.idle(1);
  endtask : setup

  // One read and the full frame of its data
  task burst(input logic [1:0] m, input logic sel, input logic [5:0] lat, input logic full, input logic [63:0] d);
    setup(m, lat, 1'b1, d);
    ctl.issue(1'b1, 1'b0, sel, 2'h1);
    repeat (lat - 1) @(posedge linkClk);
    #140 `CHK(dqOe, 1'b0)
    `CHK(readBurstBeats, full ? srbt_pkg::BEATS_FULL : srbt_pkg::BEATS_CHOP)
    for (int c = 0; c < (full ? 4 : 2); c++) begin
      @(posedge linkClk);
      // Both samples stay inside this clock so the next rise is not skipped
      #90 `CHK(dqOe, 1'b1)
      `CHK(dqOut, d[16*c +: 8])
      #100 `CHK(dqOut, d[16*c+8 +: 8])
    end
    @(posedge linkClk);
    #140 `CHK(dqOe, 1'b0)
    `CHK(dqOut, d[(full ? 56 : 24) +: 8])
    ctl.idle(4);
  endtask : burst

  // Two commands g rises apart; the second is the opposite kind
  task gap(input logic rdFirst, input logic [1:0] m, input int g, input logic [1:0] bg2,
           input logic expFlag, input logic [3:0] expWrBeats);
    setup(m, 6'h05, 1'b1, 64'h0);
    sawRw = 1'b0;
    sawWr = 1'b0;
    ctl.issue(rdFirst, ~rdFirst, 1'b0, 2'h0);
    ctl.idle(g - 1);
    ctl.issue(~rdFirst, rdFirst, 1'b0, bg2);
    ctl.idle(14);
    `CHK(rdFirst ? sawRw : sawWr, expFlag)
    `CHK(rdFirst ? sawWr : sawRw, 1'b0)
    `CHK(writeBurstBeats, expWrBeats)
  endtask : gap

  // Verdict and end of run
  task results;
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Watchdog, well past the few hundred memory clocks of the sequence
  initial begin
    #400000;
    n_errors++;
    results();
  end

  // Main sequence
  initial begin
    core_clk = 1'b0;
    rstn = 1'b0;
    burstMode = srbt_pkg::MODE_FIXED_FULL;
    readCasLatency = 6'h05;
    writeCasLatency = 6'h04;
    writePreambleTime = 2'h1;
    wrToRdDelayLong = 4'h4;
    wrToRdDelayShort = 4'h2;
    dllLocked = 1'b1;
    burstData = 64'h0;
    sawRw = 1'b0;
    sawWr = 1'b0;
    sawOe = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (20) @(posedge core_clk);
    `CHK(dqOe, 1'b0)
    `CHK(readBurstBeats, srbt_pkg::BEATS_FULL)
    #2 rstn = 1'b1;
    burst(srbt_pkg::MODE_FIXED_FULL, 1'b0, 6'h03, 1'b1, 64'h0123456789ABCDEF);
    burst(srbt_pkg::MODE_PER_CMD, 1'b1, 6'h05, 1'b1, 64'hFEDCBA9876543210);
    burst(srbt_pkg::MODE_PER_CMD, 1'b0, 6'h04, 1'b0, 64'h00000000A55A3CC3);
    burst(srbt_pkg::MODE_FIXED_CHOP, 1'b1, 6'h03, 1'b0, 64'h0000000096E10F78);
    // Unlocked loop: the read must not drive the pins
    setup(srbt_pkg::MODE_FIXED_FULL, 6'h03, 1'b0, 64'h1111111111111111);
    sawOe = 1'b0;
    ctl.issue(1'b1, 1'b0, 1'b1, 2'h0);
    ctl.idle(10);
    `CHK(sawOe, 1'b0)
    gap(1'b1, srbt_pkg::MODE_FIXED_FULL, 6, 2'h0, 1'b1, srbt_pkg::BEATS_FULL);
    gap(1'b1, srbt_pkg::MODE_FIXED_FULL, 7, 2'h2, 1'b0, srbt_pkg::BEATS_FULL);
    gap(1'b1, srbt_pkg::MODE_FIXED_CHOP, 4, 2'h0, 1'b1, srbt_pkg::BEATS_CHOP);
    gap(1'b1, srbt_pkg::MODE_FIXED_CHOP, 5, 2'h0, 1'b0, srbt_pkg::BEATS_CHOP);
    gap(1'b1, srbt_pkg::MODE_PER_CMD, 4, 2'h0, 1'b1, srbt_pkg::BEATS_FULL);
    gap(1'b0, srbt_pkg::MODE_FIXED_FULL, 11, 2'h0, 1'b1, srbt_pkg::BEATS_FULL);
    gap(1'b0, srbt_pkg::MODE_FIXED_FULL, 12, 2'h0, 1'b0, srbt_pkg::BEATS_FULL);
    gap(1'b0, srbt_pkg::MODE_FIXED_FULL, 9, 2'h2, 1'b1, srbt_pkg::BEATS_FULL);
    gap(1'b0, srbt_pkg::MODE_FIXED_FULL, 10, 2'h2, 1'b0, srbt_pkg::BEATS_FULL);
    gap(1'b0, srbt_pkg::MODE_FIXED_CHOP, 10, 2'h0, 1'b0, srbt_pkg::BEATS_CHOP);
    results();
  end
endmodule : srbt_read_burst_tb
